// ---- ppisr_defs.svh ----
`ifndef PPISR_DEFS_SVH
`define PPISR_DEFS_SVH

// =============================================================
// Register addresses
`define PPISR_ADDR_PUMP1     7'h1c
`define PPISR_ADDR_OFFSET    7'h1d
`define PPISR_ADDR_PUMP2     7'h1e
`define PPISR_ADDR_SEL_A     7'h20
`define PPISR_ADDR_SEL_B     7'h21
`define PPISR_ADDR_CNT_HIGH  7'h22
`define PPISR_ADDR_CNT_LIM   7'h23

// =============================================================
// Field positions
`define PPISR_OFS_EN_BIT     5
`define PPISR_MON_DIV_HI     4
`define PPISR_MON_DIV_LO     3
`define PPISR_IN_BLOCK_BIT   2
`define PPISR_HOLDOVER_BIT   1
`define PPISR_SRC_BIT        0
`define PPISR_REVERT_BIT     4
`define PPISR_MODE_HI        3
`define PPISR_MODE_LO        2
`define PPISR_INT_SEL_BIT    0

// =============================================================
// Reset values
`define PPISR_PUMP1_RST      5'h0f
`define PPISR_PUMP2_RST      5'h06
`define PPISR_OFFSET_RST     5'h00
`define PPISR_BYTE_RST       8'h00

// =============================================================
// Current and phase scaling
`define PPISR_PUMP1_STEP_UA  50
`define PPISR_PUMP2_STEP_UA  200
`define PPISR_OFS_TENTH_DEG  9

`endif

// ---- ppisr_pkg.sv ----
package ppisr_pkg;
   typedef logic [7:0] ppisr_byte_t;
   typedef logic [6:0] ppisr_addr_t;
   typedef logic [4:0] ppisr_code_t;
   typedef enum logic {
      PPISR_SRC_PIN,
      PPISR_SRC_BIT
   } ppisr_src_t;
endpackage

// ---- ppisr_bus_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface ppisr_bus_if;
   import ppisr_pkg::*;
   ppisr_addr_t addr;
   ppisr_byte_t wdata;
   logic        wr_en;
   ppisr_byte_t rdata;
   modport port (output addr, output wdata, output wr_en, input rdata);
   modport regs (input addr, input wdata, input wr_en, output rdata);
endinterface
`default_nettype wire

// ---- ppisr_spi_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module ppisr_spi_port
   import ppisr_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic spi_sclk,
   input  wire logic spi_cs_n,
   input  wire logic spi_mosi,
   output logic      spi_miso,
   output logic      spi_miso_oe,
   ppisr_bus_if.port bus
);
   // =============================================================
   // Pin synchronisers
   logic [1:0] sclk_sync_reg;
   logic [1:0] cs_sync_reg;
   logic [1:0] mosi_sync_reg;
   logic       sclk_last_reg;
   logic       rise;
   logic       fall;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_sync_reg <= 2'h0;
         cs_sync_reg   <= 2'h3;
         mosi_sync_reg <= 2'h0;
         sclk_last_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk};
         cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n};
         mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
         sclk_last_reg <= sclk_sync_reg[1];
      end
   end

   assign rise = sclk_sync_reg[1] & ~sclk_last_reg & ~cs_sync_reg[1];
   assign fall = ~sclk_sync_reg[1] & sclk_last_reg & ~cs_sync_reg[1];

   // =============================================================
   // Frame: read flag, 7-bit address, 8 data bits, MSB first
   logic [4:0]  bit_cnt_reg;
   logic [6:0]  shift_reg;
   logic        is_read_reg;
   logic        load_reg;
   ppisr_byte_t rd_shift_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_reg <= 5'h00;
         shift_reg   <= 7'h00;
         is_read_reg <= 1'b0;
         load_reg    <= 1'b0;
         bus.addr    <= 7'h00;
         bus.wdata   <= 8'h00;
         bus.wr_en   <= 1'b0;
      end else begin
         bus.wr_en <= 1'b0;
         load_reg  <= 1'b0;
         if (cs_sync_reg[1]) begin
            bit_cnt_reg <= 5'h00;
         end else if (rise && bit_cnt_reg < 5'h10) begin
            shift_reg   <= {shift_reg[5:0], mosi_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h07) begin
               is_read_reg <= shift_reg[6];
               bus.addr    <= {shift_reg[5:0], mosi_sync_reg[1]};
               load_reg    <= 1'b1;
            end
            if (bit_cnt_reg == 5'h0f && !is_read_reg) begin
               bus.wdata <= {shift_reg, mosi_sync_reg[1]};
               bus.wr_en <= 1'b1;
            end
         end
      end
   end

   // The read byte is captured once, so a frame sees one consistent value.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_shift_reg <= 8'h00;
         spi_miso     <= 1'b0;
         spi_miso_oe  <= 1'b0;
      end else if (cs_sync_reg[1]) begin
         spi_miso_oe <= 1'b0;
         spi_miso    <= 1'b0;
      end else if (load_reg) begin
         rd_shift_reg <= bus.rdata;
      end else if (fall && is_read_reg && bit_cnt_reg >= 5'h08
                   && bit_cnt_reg < 5'h10) begin
         spi_miso     <= rd_shift_reg[7];
         spi_miso_oe  <= 1'b1;
         rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
   end
endmodule // ppisr_spi_port
`default_nettype wire

// ---- ppisr_regs.sv ----
// Operation
// (RULE1) First loop pump current is 50 uA times code plus one.
// (RULE2) First loop pump code resets to 0x0f, 0.8 mA; code zero is 50 uA.
// (RULE3) Offset enable, reset 0, gates the static phase offset onto detector.
// (RULE4) Phase offset is code times 0.9 degrees; code resets to zero.
// (RULE5) Software sets offset above detector rate times jitter times 400.
// (RULE6) Second loop pump is 200 uA times code plus one; resets to 1.4 mA.
// (RULE7) Register 0x20: divider 4:3, block 2, holdover 1, source 0.
// (RULE8) Register 0x21: revertive 4, mode 3:2, internal select 0.
// (RULE9) Register 0x22 full counter byte; 0x23 fields at 7:6 and 1:0.
// (RULE10) Monitor divider divides oscillator clock by 1, 2, 4 or 8.
// (RULE11) Source bit picks external select pin or internal select bit.
// (RULE12) Reserved bits ignore writes and read back as zero.
`timescale 1ns/1ns
`default_nettype none
`include "ppisr_defs.svh"
module ppisr_regs
   import ppisr_pkg::*;
#(
   parameter ppisr_byte_t CNT_HIGH_RST = `PPISR_BYTE_RST,
   parameter ppisr_byte_t CNT_LIM_RST  = `PPISR_BYTE_RST
)(
   input  wire logic   clk,
   input  wire logic   nrst,
   input  wire logic   spi_sclk,
   input  wire logic   spi_cs_n,
   input  wire logic   spi_mosi,
   output logic        spi_miso,
   output logic        spi_miso_oe,
   input  wire logic   external_select_pin,
   output ppisr_code_t first_loop_pump_code,
   output logic [10:0] first_loop_pump_ua,
   output logic        phase_offset_enable,
   output ppisr_code_t static_phase_offset,
   output logic [8:0]  applied_offset_tenth_deg,
   output ppisr_code_t second_loop_pump_code,
   output logic [12:0] second_loop_pump_ua,
   output logic [1:0]  monitor_divider,
   output logic        monitor_clk_en,
   output logic        inactive_input_block,
   output logic        holdover_control_select,
   output ppisr_src_t  selection_source,
   output logic        revertive_switching,
   output logic [1:0]  manual_auto_mode,
   output logic        internal_select,
   output logic        selected_input,
   output ppisr_byte_t counter_high_field,
   output logic [1:0]  counter_r_field,
   output logic [1:0]  counter_v_field
);
   // =============================================================
   // Serial port
   ppisr_bus_if bus ();

   ppisr_spi_port u_port (
      .clk         (clk),
      .nrst        (nrst),
      .spi_sclk    (spi_sclk),
      .spi_cs_n    (spi_cs_n),
      .spi_mosi    (spi_mosi),
      .spi_miso    (spi_miso),
      .spi_miso_oe (spi_miso_oe),
      .bus         (bus.port)
   );

   logic        wr;
   ppisr_byte_t d;
   assign wr = bus.wr_en;
   assign d  = bus.wdata;

   // =============================================================
   // Loop settings
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         first_loop_pump_code  <= `PPISR_PUMP1_RST; // RULE2
         second_loop_pump_code <= `PPISR_PUMP2_RST; // RULE6
         phase_offset_enable   <= 1'b0; // RULE3
         static_phase_offset   <= `PPISR_OFFSET_RST; // RULE4
      end else if (wr) begin
         if (bus.addr == `PPISR_ADDR_PUMP1)
            first_loop_pump_code <= d[4:0];
         if (bus.addr == `PPISR_ADDR_PUMP2)
            second_loop_pump_code <= d[4:0];
         if (bus.addr == `PPISR_ADDR_OFFSET) begin
            phase_offset_enable <= d[`PPISR_OFS_EN_BIT];
            static_phase_offset <= d[4:0];
         end
      end
   end

   // The analogue trims take these ready-scaled values, one cycle later.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         first_loop_pump_ua       <= 11'h000;
         second_loop_pump_ua      <= 13'h0000;
         applied_offset_tenth_deg <= 9'h000;
      end else begin
         first_loop_pump_ua  <= 11'(`PPISR_PUMP1_STEP_UA *
                                   (first_loop_pump_code + 6'h01)); // RULE1
         second_loop_pump_ua <= 13'(`PPISR_PUMP2_STEP_UA *
                                   (second_loop_pump_code + 6'h01)); // RULE6
         applied_offset_tenth_deg <= phase_offset_enable ?
            9'(`PPISR_OFS_TENTH_DEG * static_phase_offset) : 9'h000; // RULE3
      end
   end

   // =============================================================
   // Input selection registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         monitor_divider         <= 2'h0; // RULE10
         inactive_input_block    <= 1'b0;
         holdover_control_select <= 1'b0;
         selection_source        <= PPISR_SRC_PIN;
         revertive_switching     <= 1'b0;
         manual_auto_mode        <= 2'h0;
         internal_select         <= 1'b0;
         counter_high_field      <= CNT_HIGH_RST;
         counter_r_field         <= CNT_LIM_RST[7:6];
         counter_v_field         <= CNT_LIM_RST[1:0];
      end else if (wr) begin
         case (bus.addr)
            `PPISR_ADDR_SEL_A: begin // RULE7
               monitor_divider <= d[`PPISR_MON_DIV_HI:`PPISR_MON_DIV_LO];
               inactive_input_block    <= d[`PPISR_IN_BLOCK_BIT];
               holdover_control_select <= d[`PPISR_HOLDOVER_BIT];
               selection_source <= ppisr_src_t'(d[`PPISR_SRC_BIT]);
            end
            `PPISR_ADDR_SEL_B: begin // RULE8
               revertive_switching <= d[`PPISR_REVERT_BIT];
               manual_auto_mode    <= d[`PPISR_MODE_HI:`PPISR_MODE_LO];
               internal_select     <= d[`PPISR_INT_SEL_BIT];
            end
            `PPISR_ADDR_CNT_HIGH: counter_high_field <= d; // RULE9
            `PPISR_ADDR_CNT_LIM: begin // RULE9
               counter_r_field <= d[7:6];
               counter_v_field <= d[1:0];
            end
            default: ;
         endcase
      end
   end

   // =============================================================
   // Read mux; unlisted bits stay zero whatever was written.
   always_comb begin
      bus.rdata = 8'h00; // RULE12
      case (bus.addr)
         `PPISR_ADDR_PUMP1:    bus.rdata = {3'h0, first_loop_pump_code};
         `PPISR_ADDR_OFFSET:   bus.rdata = {2'h0, phase_offset_enable,
                                            static_phase_offset};
         `PPISR_ADDR_PUMP2:    bus.rdata = {3'h0, second_loop_pump_code};
         `PPISR_ADDR_SEL_A:    bus.rdata = {3'h0, monitor_divider,
                                            inactive_input_block,
                                            holdover_control_select,
                                            selection_source};
         `PPISR_ADDR_SEL_B:    bus.rdata = {3'h0, revertive_switching,
                                            manual_auto_mode, 1'b0,
                                            internal_select};
         `PPISR_ADDR_CNT_HIGH: bus.rdata = counter_high_field;
         `PPISR_ADDR_CNT_LIM:  bus.rdata = {counter_r_field, 4'h0,
                                            counter_v_field};
         default:              bus.rdata = 8'h00;
      endcase
   end

   // =============================================================
   // Activity monitor clock enable
   logic [2:0] div_cnt_reg;
   logic [2:0] div_mask;
   assign div_mask = 3'((4'h1 << monitor_divider) - 4'h1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_reg    <= 3'h0;
         monitor_clk_en <= 1'b0;
      end else begin
         div_cnt_reg    <= div_cnt_reg + 3'h1;
         monitor_clk_en <= (div_cnt_reg & div_mask) == 3'h0; // RULE10
      end
   end

   // =============================================================
   // Input select; the pin is asynchronous so it is synchronised first.
   logic [1:0] ext_sync_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_sync_reg   <= 2'h0;
         selected_input <= 1'b0;
      end else begin
         ext_sync_reg   <= {ext_sync_reg[0], external_select_pin};
         selected_input <= (selection_source == PPISR_SRC_BIT) ?
                           internal_select : ext_sync_reg[1]; // RULE11
      end
   end

   // =============================================================
   // Assertions
   logic after_rst_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         after_rst_reg <= 1'b0;
      else
         after_rst_reg <= 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   pump1_scale_a: assert property (nrst |=> first_loop_pump_ua ==
      11'(50 * ($past(first_loop_pump_code) + 6'h01))) // RULE1
      else $error("first loop pump current wrong");
   pump1_reset_a: assert property (!after_rst_reg |->
      first_loop_pump_code == 5'h0f && second_loop_pump_code == 5'h06
      && !phase_offset_enable && static_phase_offset == 5'h00) // RULE2
      else $error("loop settings reset wrong");
   offset_gate_a: assert property (1'b1 |=> applied_offset_tenth_deg ==
      ($past(phase_offset_enable) ? 9'($past(static_phase_offset) * 9)
      : 9'h000)) // RULE3
      else $error("offset gating wrong");
   offset_write_a: assert property (wr && bus.addr == 7'h1d |=>
      static_phase_offset == $past(d[4:0])
      && phase_offset_enable == $past(d[5])) // RULE4
      else $error("offset write lost");
   pump2_scale_a: assert property (nrst |=> second_loop_pump_ua ==
      13'(200 * ($past(second_loop_pump_code) + 6'h01))) // RULE6
      else $error("second loop pump current wrong");
   sel_a_map_a: assert property (wr && bus.addr == 7'h20 |=>
      monitor_divider == $past(d[4:3]) && holdover_control_select ==
      $past(d[1]) && selection_source == ppisr_src_t'($past(d[0]))) // RULE7
      else $error("register 0x20 map wrong");
   sel_b_map_a: assert property (wr && bus.addr == 7'h21 |=>
      revertive_switching == $past(d[4]) && manual_auto_mode ==
      $past(d[3:2]) && internal_select == $past(d[0])) // RULE8
      else $error("register 0x21 map wrong");
   cnt_map_a: assert property (wr && bus.addr == 7'h23 |=>
      counter_r_field == $past(d[7:6])
      && counter_v_field == $past(d[1:0])) // RULE9
      else $error("register 0x23 map wrong");
   mon_div8_a: assert property (monitor_clk_en && monitor_divider == 2'h3
      && $past(monitor_divider) == 2'h3 |=> !monitor_clk_en) // RULE10
      else $error("monitor divide by eight wrong");
   mon_div1_a: assert property ((nrst && monitor_divider == 2'h0) [*2]
      |-> monitor_clk_en) // RULE10
      else $error("monitor divide by one wrong");
   select_src_a: assert property (1'b1 |=> selected_input ==
      ($past(selection_source) == PPISR_SRC_BIT ? $past(internal_select)
      : $past(ext_sync_reg[1]))) // RULE11
      else $error("input selection wrong");
   reserved_zero_a: assert property (bus.addr == 7'h21 |->
      bus.rdata[7:5] == 3'h0 && bus.rdata[1] == 1'b0) // RULE12
      else $error("reserved bits not zero");

   wr_pump1_c: cover property (wr && bus.addr == 7'h1c);
   offset_on_c: cover property (phase_offset_enable
      && static_phase_offset == 5'h1f);
   src_bit_c:   cover property (selection_source == PPISR_SRC_BIT
      ##1 selected_input);
   div8_c:      cover property (monitor_divider == 2'h3 && monitor_clk_en);
endmodule // ppisr_regs
`default_nettype wire

// ---- ppisr_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ppisr_defs.svh"
module testbench;
   import ppisr_pkg::*;
   // ==========================================================
   // Pins and observed fields
   logic        clk;
   logic        nrst;
   logic        spi_sclk;
   logic        spi_cs_n;
   logic        spi_mosi;
   logic        spi_miso;
   logic        spi_miso_oe;
   logic        ext_pin;
   ppisr_code_t pump1_code;
   logic [10:0] pump1_ua;
   logic        ofs_en;
   ppisr_code_t ofs_code;
   logic [8:0]  ofs_applied;
   ppisr_code_t pump2_code;
   logic [12:0] pump2_ua;
   logic [1:0]  mon_div;
   logic        mon_en;
   logic        in_block;
   logic        holdover;
   ppisr_src_t  sel_src;
   logic        revert;
   logic [1:0]  ma_mode;
   logic        int_sel;
   logic        sel_in;
   ppisr_byte_t cnt_high;
   logic [1:0]  cnt_r;
   logic [1:0]  cnt_v;
   int          n_errors;
   int          compares;
   int          k;
   int          cnt;
   logic [7:0]  d;

   ppisr_regs DUT (
      .clk                      (clk),
      .nrst                     (nrst),
      .spi_sclk                 (spi_sclk),
      .spi_cs_n                 (spi_cs_n),
      .spi_mosi                 (spi_mosi),
      .spi_miso                 (spi_miso),
      .spi_miso_oe              (spi_miso_oe),
      .external_select_pin      (ext_pin),
      .first_loop_pump_code     (pump1_code),
      .first_loop_pump_ua       (pump1_ua),
      .phase_offset_enable      (ofs_en),
      .static_phase_offset      (ofs_code),
      .applied_offset_tenth_deg (ofs_applied),
      .second_loop_pump_code    (pump2_code),
      .second_loop_pump_ua      (pump2_ua),
      .monitor_divider          (mon_div),
      .monitor_clk_en           (mon_en),
      .inactive_input_block     (in_block),
      .holdover_control_select  (holdover),
      .selection_source         (sel_src),
      .revertive_switching      (revert),
      .manual_auto_mode         (ma_mode),
      .internal_select          (int_sel),
      .selected_input           (sel_in),
      .counter_high_field       (cnt_high),
      .counter_r_field          (cnt_r),
      .counter_v_field          (cnt_v)
   );

   // ==========================================================
   // Checking and verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Serial frame, mode 0, sclk low for seven clocks and high for six
   // Seven clocks low and six high per bit leave room for the pin synchroniser
   // and the one-cycle data lag before miso is sampled.
   task automatic frame(input logic rw, input logic [6:0] a,
                        input logic [7:0] wd, output logic [7:0] q);
      logic [15:0] w;
      w = {rw, a, wd};
      q = 8'h00;
      @(posedge clk);
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk);
         spi_sclk <= 1'b0;
         spi_mosi <= w[i];
         repeat (6) @(posedge clk);
         if (rw && i < 8) begin
            @(negedge clk);
            q[i] = spi_miso;
            check({15'h0, spi_miso_oe}, 16'h0001);
         end
         @(posedge clk);
         spi_sclk <= 1'b1;
         repeat (5) @(posedge clk);
      end
      @(posedge clk);
      spi_sclk <= 1'b0;
      repeat (6) @(posedge clk);
      spi_cs_n <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] wd);
      logic [7:0] q;
      frame(1'b0, a, wd, q);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] q;
      frame(1'b1, a, 8'h00, q);
      check({8'h0, q}, {8'h0, exp});
      check({15'h0, spi_miso_oe}, 16'h0000);
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      print_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      n_errors = 0;
      compares = 0;
      nrst     = 1'b0;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      ext_pin  = 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(negedge clk);
      check({11'h0, pump1_code}, 16'h000f);
      check({5'h0, pump1_ua}, 16'd800);
      check({10'h0, ofs_en, ofs_code}, 16'h0000);
      check({7'h0, ofs_applied}, 16'h0000);
      check({3'h0, pump2_ua}, 16'd1400);
      check({11'h0, mon_div, in_block, holdover, sel_src}, 16'h0000);
      check({cnt_high, 2'h0, cnt_r, cnt_v, revert, 1'b0}, 16'h0000);
      rd(`PPISR_ADDR_PUMP1, 8'h0f);
      rd(`PPISR_ADDR_OFFSET, 8'h00);
      rd(`PPISR_ADDR_PUMP2, 8'h06);
      rd(`PPISR_ADDR_SEL_A, 8'h00);
      // Boundary codes, reserved bit 5 set on every write.
      for (k = 0; k < 32; k += 15) begin
         d = 8'(k) + 8'(k / 30);
         wr(`PPISR_ADDR_PUMP1, 8'h20 | d);
         check({5'h0, pump1_ua}, 16'(50 * (d + 1)));
         rd(`PPISR_ADDR_PUMP1, d);
         wr(`PPISR_ADDR_PUMP2, 8'he0 | d);
         check({3'h0, pump2_ua}, 16'(200 * (d + 1)));
         check({11'h0, pump2_code}, {8'h0, d});
         rd(`PPISR_ADDR_PUMP2, d);
      end
      // Offset code applied only while enabled.
      for (k = 0; k < 4; k++) begin
         d = (k == 0) ? 8'h1f : (k == 1) ? 8'hff : (k == 2) ? 8'h21 : 8'h00;
         wr(`PPISR_ADDR_OFFSET, d);
         check({10'h0, ofs_en, ofs_code}, {8'h0, d & 8'h3f});
         check({7'h0, ofs_applied}, d[5] ? 16'(d[4:0] * 9) : 16'h0);
         rd(`PPISR_ADDR_OFFSET, d & 8'h3f);
      end
      // Every divider code, pulses counted over sixteen clocks.
      for (k = 0; k < 4; k++) begin
         wr(`PPISR_ADDR_SEL_A, 8'(k << 3));
         cnt = 0;
         repeat (16) begin
            @(negedge clk);
            cnt += (mon_en === 1'b1) ? 1 : 0;
         end
         check(16'(cnt), 16'(16 >> k));
         rd(`PPISR_ADDR_SEL_A, 8'(k << 3));
      end
      wr(`PPISR_ADDR_SEL_A, 8'hff);
      check({11'h0, mon_div, in_block, holdover, sel_src}, 16'h001f);
      rd(`PPISR_ADDR_SEL_A, 8'h1f);
      wr(`PPISR_ADDR_SEL_B, 8'hff);
      check({12'h0, revert, ma_mode, int_sel}, 16'h000f);
      rd(`PPISR_ADDR_SEL_B, 8'h1d);
      // Source bit set: internal bit chooses, pin ignored.
      @(posedge clk);
      ext_pin <= 1'b0;
      repeat (6) @(negedge clk);
      check({15'h0, sel_in}, 16'h0001);
      wr(`PPISR_ADDR_SEL_B, 8'h08);
      check({15'h0, sel_in}, 16'h0000);
      // Source bit clear: the pin chooses.
      wr(`PPISR_ADDR_SEL_A, 8'h00);
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (6) @(negedge clk);
      check({15'h0, sel_in}, 16'h0001);
      @(posedge clk);
      ext_pin <= 1'b0;
      repeat (6) @(negedge clk);
      check({15'h0, sel_in}, 16'h0000);
      rd(`PPISR_ADDR_SEL_B, 8'h08);
      wr(`PPISR_ADDR_CNT_HIGH, 8'ha5);
      check({8'h0, cnt_high}, 16'h00a5);
      rd(`PPISR_ADDR_CNT_HIGH, 8'ha5);
      wr(`PPISR_ADDR_CNT_LIM, 8'hff);
      rd(`PPISR_ADDR_CNT_LIM, 8'hc3);
      wr(`PPISR_ADDR_CNT_LIM, 8'h81);
      check({12'h0, cnt_r, cnt_v}, 16'h0009);
      // Unmapped place: write dropped, read gives zero.
      wr(7'h30, 8'hff);
      rd(7'h30, 8'h00);
      check({11'h0, pump1_code}, 16'h001f);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
